//--- hdl/core_seq_pkg.sv
// Purpose: shared constants and types for the core regulator start-up sequencer
// Assumes: pclk at 125 MHz
// Notes: APB map, status bits and timing figures live here
package core_seq_pkg;
  localparam int unsigned clk_mhz = 125; // pclk rate
  localparam int unsigned ramp_delay_us = 100; // enable to ramp start
  localparam int unsigned ramp_delay_cycles = ramp_delay_us * clk_mhz;
  localparam int unsigned output_power_good_delay_ms = 7; // clock enable to power good
  localparam int unsigned output_power_good_delay_cycles = output_power_good_delay_ms * 1000 * clk_mhz;
  localparam int unsigned qual_cycles = 6; // switching cycles of good input
  localparam int unsigned sw_div_default = 416; // pclk per switching cycle, ~300 kHz
  // voltage code decode, in units of 0.1 mV
  localparam int unsigned code_zero_tenth_mv = 15000; // 1.5 V
  localparam int unsigned code_step_tenth_mv = 125; // 12.5 mV per step
  localparam int unsigned boot_tenth_mv = 12000; // 1.2 V
  localparam int unsigned boot_window_tenth_mv = 1200; // 10 % of boot
  localparam int unsigned code_width = 7;
  localparam int unsigned mv_width = 16;
  // apb byte addresses
  localparam logic [7:0] addr_ctrl = 8'h00;
  localparam logic [7:0] addr_status = 8'h04;
  localparam logic [7:0] addr_irq_stat = 8'h08;
  localparam logic [7:0] addr_irq_mask = 8'h0C;
  localparam logic [7:0] addr_target = 8'h10;
  // irq status bit positions
  localparam int unsigned irq_clk_en = 0; // clock enable asserted
  localparam int unsigned irq_output_power_good = 1; // power good released
  localparam int unsigned irq_latch = 2; // latched off
  localparam int unsigned irq_width = 3;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [31:0] slverr_data = 32'h0000_0000;
  typedef enum {st_off, st_delay, st_ramp, st_slew, st_run, st_latched} state_type;
  // slew and conduction mode outputs travel together
  typedef struct packed {
    logic fast_slew; // large soft current
    logic ramp_active; // soft reference moving
    logic diode_emulation_mode; // else continuous conduction
    logic wide_window; // widened hysteresis
  } mode_type;
endpackage : core_seq_pkg

//--- hdl/core_regulator_startup_sequencer.sv
// Purpose: start-up, latch-off and low-power mode sequencer of a core regulator
// Assumes: inputs synchronous to pclk; analog loop outside reads target and mode
// Notes: apb exposes control, status, sticky events and the decoded target
// Operation
// - enable input high with control bit0 set runs the controller
// - ramp toward 1.2 V after 100 us
// - start-up forces continuous conduction, ignores sleep pins
// - boot ramp uses slow slew
// - clock enable after boot window and six cycles
// - after clock enable, fast slew to code level
// - power good seven ms after clock enable
// - upstream good low latches converter off
// - only enable toggle clears latch
// - forced emulation with wake high low gives emulation
// - deep sleep request selects slow slew
// - code bit zero is least significant
// - code zero 1.5 V, minus 12.5 mV per step
`timescale 1ns/10ps
module core_regulator_startup_sequencer #(
  parameter int unsigned ramp_cycles = core_seq_pkg::ramp_delay_cycles,
  parameter int unsigned output_power_good_cycles = core_seq_pkg::output_power_good_delay_cycles,
  parameter int unsigned sw_div = core_seq_pkg::sw_div_default
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic regulator_enable_in,
  input wire logic upstream_power_good_in,
  input wire logic forced_emulation_enable,
  input wire logic slow_wake_sleep_n,
  input wire logic deep_sleep_request,
  input wire logic [6:0] voltage_code,
  input wire logic [15:0] output_voltage_sense, // measured output, 0.1 mV units
  output logic clock_enable_n,
  output logic output_power_good_o,
  output logic output_power_good_oe,
  output logic converter_on,
  output logic [15:0] target_tenth_mv,
  output core_seq_pkg::mode_type mode,
  output logic irq
);
  core_seq_pkg::state_type state_reg;
  logic [31:0] timer_reg; // delay counter shared by ramp and good waits
  logic [9:0] div_reg; // switching-cycle divider
  logic sw_tick; // one pulse per switching cycle
  logic [2:0] qual_reg; // qualifying switching cycles
  logic enable_prev_reg; // for the rising edge of enable
  logic soft_enable_reg; // software gate, bit0 of control
  logic [core_seq_pkg::irq_width-1:0] irq_stat_reg;
  logic [core_seq_pkg::irq_width-1:0] irq_mask_reg;
  logic [core_seq_pkg::irq_width-1:0] irq_set;
  logic in_window; // output inside boot window
  logic run_enable; // pin and software both allow running
  logic apb_wr; // write access phase
  logic apb_rd; // read access phase
  logic [7:0] addr;
  logic latched_prev_reg; // latch state seen last cycle, for one event pulse
  // one timer serves both waits; the ramp and good waits never overlap
  // the divider width limits sw_div to 1024 pclk per switching cycle

  // decode the voltage code; bit0 lsb
  function automatic logic [15:0] decode_code(input logic [6:0] code);
    decode_code = 16'(core_seq_pkg::code_zero_tenth_mv
                      - core_seq_pkg::code_step_tenth_mv * code);
  endfunction : decode_code

  assign addr = paddr[7:0];
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & penable & ~pwrite;
  assign run_enable = regulator_enable_in & soft_enable_reg;
  assign in_window =
    (output_voltage_sense + 16'(core_seq_pkg::boot_window_tenth_mv)
       >= 16'(core_seq_pkg::boot_tenth_mv)) &&
    (output_voltage_sense
       <= 16'(core_seq_pkg::boot_tenth_mv + core_seq_pkg::boot_window_tenth_mv));
  assign sw_tick = (div_reg == 10'(sw_div - 1));

  // switching-cycle divider, free running
  // runs even while off, so the phase of the first tick is arbitrary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
    end else if (sw_tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 10'd1;
    end
  end

  // enable history, for clearing the latch on a fresh enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_prev_reg <= 1'b0;
    end else begin
      enable_prev_reg <= run_enable;
    end
  end

  // main sequence
  // enable low wins over every state, the only way out of the latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= core_seq_pkg::st_off;
      timer_reg <= '0;
      qual_reg <= '0;
    end else if (!run_enable) begin
      state_reg <= core_seq_pkg::st_off; // enable low ends everything
      timer_reg <= '0;
      qual_reg <= '0;
    end else begin
      case (state_reg)
        core_seq_pkg::st_off: begin
          // a latch only left via enable low, so off means fresh start
          if (!enable_prev_reg) begin
            state_reg <= core_seq_pkg::st_delay;
          end
          timer_reg <= '0;
        end
        core_seq_pkg::st_delay: begin
          if (!upstream_power_good_in) begin
            state_reg <= core_seq_pkg::st_latched;
          end else if (timer_reg >= ramp_cycles - 1) begin
            state_reg <= core_seq_pkg::st_ramp;
            timer_reg <= '0;
          end else begin
            timer_reg <= timer_reg + 32'd1;
          end
        end
        core_seq_pkg::st_ramp: begin
          if (!upstream_power_good_in) begin
            state_reg <= core_seq_pkg::st_latched;
            qual_reg <= '0;
          end else if (!in_window) begin
            qual_reg <= '0;
          end else if (sw_tick) begin
            if (qual_reg == 3'(core_seq_pkg::qual_cycles - 1)) begin
              state_reg <= core_seq_pkg::st_slew;
              qual_reg <= '0;
              timer_reg <= '0;
            end else begin
              qual_reg <= qual_reg + 3'd1;
            end
          end
        end
        core_seq_pkg::st_slew: begin
          if (!upstream_power_good_in) begin
            state_reg <= core_seq_pkg::st_latched;
          end else if (timer_reg >= output_power_good_cycles - 1) begin
            state_reg <= core_seq_pkg::st_run;
          end else begin
            timer_reg <= timer_reg + 32'd1;
          end
        end
        core_seq_pkg::st_run: begin
          if (!upstream_power_good_in) begin
            state_reg <= core_seq_pkg::st_latched;
          end
        end
        default: begin
          state_reg <= core_seq_pkg::st_latched; // upstream return ignored
        end
      endcase
    end
  end

  // registered pin outputs
  // outputs lag the state by one cycle; the analog loop tolerates that
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_enable_n <= 1'b1;
      output_power_good_o <= 1'b0;
      output_power_good_oe <= 1'b1;
      converter_on <= 1'b0;
      target_tenth_mv <= '0;
      mode <= '0;
    end else begin
      clock_enable_n <= !(state_reg == core_seq_pkg::st_slew ||
                          state_reg == core_seq_pkg::st_run);
      // open drain: released (oe low) means high
      output_power_good_oe <= !(state_reg == core_seq_pkg::st_run);
      output_power_good_o <= 1'b0;
      converter_on <= (state_reg == core_seq_pkg::st_ramp ||
                       state_reg == core_seq_pkg::st_slew ||
                       state_reg == core_seq_pkg::st_run);
      if (state_reg == core_seq_pkg::st_ramp || state_reg == core_seq_pkg::st_delay) begin
        target_tenth_mv <= 16'(core_seq_pkg::boot_tenth_mv);
        mode.fast_slew <= 1'b0;
        mode.diode_emulation_mode <= 1'b0;
        mode.wide_window <= 1'b0;
      end else if (state_reg == core_seq_pkg::st_slew ||
                   state_reg == core_seq_pkg::st_run) begin
        target_tenth_mv <= decode_code(voltage_code);
        mode.fast_slew <= !deep_sleep_request;
        // emulation while slow_wake_sleep_n is low, widened when also forced
        mode.diode_emulation_mode <= !slow_wake_sleep_n;
        mode.wide_window <= forced_emulation_enable & !slow_wake_sleep_n;
      end else begin
        target_tenth_mv <= '0;
        mode.fast_slew <= 1'b0;
        mode.diode_emulation_mode <= 1'b0;
        mode.wide_window <= 1'b0;
      end
      mode.ramp_active <= (state_reg != core_seq_pkg::st_off &&
                           state_reg != core_seq_pkg::st_delay &&
                           state_reg != core_seq_pkg::st_latched);
    end
  end

  // event pulses: entering clock enable, power good, latch
  always_comb begin
    irq_set = '0;
    irq_set[core_seq_pkg::irq_clk_en] = clock_enable_n &&
      (state_reg == core_seq_pkg::st_slew);
    irq_set[core_seq_pkg::irq_output_power_good] = output_power_good_oe &&
      (state_reg == core_seq_pkg::st_run);
    // keyed on the state itself, so a latch out of the delay wait still counts
    irq_set[core_seq_pkg::irq_latch] = !latched_prev_reg &&
      (state_reg == core_seq_pkg::st_latched);
  end

  // latch history; without it the latch event would be raised on every cycle in the latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_prev_reg <= 1'b0;
    end else begin
      latched_prev_reg <= (state_reg == core_seq_pkg::st_latched);
    end
  end

  // software registers; set beats a write-one clear
  // writes take effect in the access phase, while pready is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_enable_reg <= core_seq_pkg::ctrl_reset[0];
      irq_mask_reg <= '0;
      irq_stat_reg <= '0;
    end else begin
      if (apb_wr && addr == core_seq_pkg::addr_ctrl) begin
        soft_enable_reg <= pwdata[0];
      end
      if (apb_wr && addr == core_seq_pkg::addr_irq_mask) begin
        irq_mask_reg <= pwdata[core_seq_pkg::irq_width-1:0];
      end
      if (apb_wr && addr == core_seq_pkg::addr_irq_stat) begin
        irq_stat_reg <= (irq_stat_reg & ~pwdata[core_seq_pkg::irq_width-1:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
    end
  end

  // apb answer: zero wait states, unmapped reads zero with error
  // trade-off: data latched in setup, so every answer is a one-cycle pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable; // ready in the first access cycle
      pslverr <= 1'b0;
      prdata <= core_seq_pkg::slverr_data;
      if (psel && !penable && !pwrite) begin
        if (addr == core_seq_pkg::addr_ctrl) begin
          prdata <= {31'h0000_0000, soft_enable_reg};
        end else if (addr == core_seq_pkg::addr_status) begin
          prdata <= {26'h000_0000, !output_power_good_oe, !clock_enable_n,
                     converter_on, 3'(state_reg)};
        end else if (addr == core_seq_pkg::addr_irq_stat) begin
          prdata <= {29'h0000_0000, irq_stat_reg};
        end else if (addr == core_seq_pkg::addr_irq_mask) begin
          prdata <= {29'h0000_0000, irq_mask_reg};
        end else if (addr == core_seq_pkg::addr_target) begin
          prdata <= {16'h0000, target_tenth_mv};
        end else begin
          pslverr <= 1'b1;
        end
      end else if (psel && !penable) begin
        pslverr <= !(addr == core_seq_pkg::addr_ctrl ||
                     addr == core_seq_pkg::addr_irq_stat ||
                     addr == core_seq_pkg::addr_irq_mask);
      end
    end
  end

  // level interrupt from masked sticky bits
  // a set mask bit lets its status bit through to the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule : core_regulator_startup_sequencer

//--- bench/core_seq_properties.sv
// Purpose: port checker for the core regulator start-up sequencer
// Assumes: delay windows below match ramp 20, power good 50, switching divide 4
// Notes: bound into the design from the foot of this file
`timescale 1ns/10ps
module core_seq_properties #(
  parameter int unsigned ramp_cycles = 20,
  parameter int unsigned output_power_good_cycles = 50,
  parameter int unsigned sw_div = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic regulator_enable_in,
  input wire logic upstream_power_good_in,
  input wire logic forced_emulation_enable,
  input wire logic slow_wake_sleep_n,
  input wire logic deep_sleep_request,
  input wire logic [6:0] voltage_code,
  input wire logic [15:0] output_voltage_sense,
  input wire logic clock_enable_n,
  input wire logic output_power_good_oe,
  input wire logic converter_on,
  input wire logic [15:0] target_tenth_mv,
  input wire core_seq_pkg::mode_type mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic in_win; // sensed output inside the boot window
  logic [7:0] good_cnt; // consecutive qualifying cycles, saturating
  assign in_win = 32'(output_voltage_sense) >= 32'(10800) && 32'(output_voltage_sense) <= 32'(13200);
  // any drop of the good input or window exit restarts the run length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) good_cnt <= 8'h00;
    else if (!(upstream_power_good_in && in_win)) good_cnt <= 8'h00;
    else if (good_cnt != 8'hFF) good_cnt <= good_cnt + 8'h01;
  end
  property p_ramp; $rose(regulator_enable_in) |-> !mode.ramp_active[*8] ##[12:16] mode.ramp_active; endproperty
  a_ramp: assert property (p_ramp) else $error("ramp start off");
  property p_ccm; converter_on && clock_enable_n |-> !mode.diode_emulation_mode && !mode.wide_window; endproperty
  a_ccm: assert property (p_ccm) else $error("start-up not continuous");
  property p_slow; converter_on && clock_enable_n |-> !mode.fast_slew; endproperty
  a_slow: assert property (p_slow) else $error("boot ramp not slow");
  property p_qual; $fell(clock_enable_n) |-> 32'(good_cnt) >= 5 * sw_div; endproperty
  a_qual: assert property (p_qual) else $error("clock enable too early");
  property p_fast; $fell(clock_enable_n) && !deep_sleep_request |-> ##[0:2] mode.fast_slew; endproperty
  a_fast: assert property (p_fast) else $error("no fast slew");
  property p_output_power_good; $fell(clock_enable_n) |-> output_power_good_oe[*8] ##[41:44] !output_power_good_oe; endproperty
  a_output_power_good: assert property (p_output_power_good) else $error("power good timing");
  property p_latch; converter_on && !upstream_power_good_in |-> ##[1:2] !converter_on && clock_enable_n; endproperty
  a_latch: assert property (p_latch) else $error("no latch off");
  property p_dem; (converter_on && !output_power_good_oe && forced_emulation_enable && !slow_wake_sleep_n)[*3]
    |-> mode.diode_emulation_mode && mode.wide_window; endproperty
  a_dem: assert property (p_dem) else $error("no emulation mode");
  property p_deep; (converter_on && !clock_enable_n && deep_sleep_request)[*3] |-> !mode.fast_slew; endproperty
  a_deep: assert property (p_deep) else $error("deep sleep not slow");
  property p_code; (converter_on && !output_power_good_oe && $stable(voltage_code))[*3]
    |-> target_tenth_mv == 16'(15000 - 125 * 32'(voltage_code)); endproperty
  a_code: assert property (p_code) else $error("code decode wrong");
  c_clk: cover property ($fell(clock_enable_n));
  c_pg: cover property ($fell(output_power_good_oe));
  c_off: cover property ($fell(converter_on));
endmodule : core_seq_properties
bind core_regulator_startup_sequencer core_seq_properties #(.ramp_cycles(ramp_cycles),
  .output_power_good_cycles(output_power_good_cycles), .sw_div(sw_div)) u_props (.pclk(pclk), .presetn(presetn),
  .regulator_enable_in(regulator_enable_in), .upstream_power_good_in(upstream_power_good_in),
  .forced_emulation_enable(forced_emulation_enable), .slow_wake_sleep_n(slow_wake_sleep_n),
  .deep_sleep_request(deep_sleep_request), .voltage_code(voltage_code),
  .output_voltage_sense(output_voltage_sense), .clock_enable_n(clock_enable_n),
  .output_power_good_oe(output_power_good_oe), .converter_on(converter_on),
  .target_tenth_mv(target_tenth_mv), .mode(mode));

//--- bench/core_host_model.sv
// Purpose: output stage and host board stand-in for the sequencer bench
// Assumes: the output follows the commanded target one cycle late
// Notes: sag drops the sensed output out of the boot window on command
`timescale 1ns/10ps
module core_host_model (
  input wire logic pclk,
  input wire logic converter_on,
  input wire logic [15:0] target_tenth_mv,
  input wire logic sag,
  input wire logic output_power_good_oe,
  input wire logic output_power_good_o,
  output logic [15:0] output_voltage_sense,
  output logic output_power_good_wire
);
  initial output_voltage_sense = 16'h0000;
  // converter off means no output at all
  always @(posedge pclk) begin
    output_voltage_sense <= !converter_on ? 16'h0000 : sag ? target_tenth_mv - 16'h07D0 : target_tenth_mv;
  end
  // external pull-up, so a released line reads high
  assign output_power_good_wire = output_power_good_oe ? output_power_good_o : 1'b1;
endmodule : core_host_model

//--- bench/tb_top.sv
// Purpose: self-checking bench for the core regulator start-up sequencer
// Assumes: shortened counts ramp 20, power good 50, switching divide 4
// Notes: the host model stands for the output stage and board pull-up
`timescale 1ns/10ps
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, clock_enable_n, output_power_good_oe, converter_on, irq, output_power_good_wire;
  logic power_good_data; // open-drain data bit, driven low while enabled
  logic enable = 1'b0, good = 1'b1, forced = 1'b0, wake_n = 1'b1, deep = 1'b0, sag = 1'b0;
  logic [6:0] code = 7'h00;
  logic [15:0] sense, target;
  core_seq_pkg::mode_type mode;
  int failures = 0, comparisons = 0, waited;
  always #4 pclk = ~pclk;
  core_regulator_startup_sequencer #(.ramp_cycles(20), .output_power_good_cycles(50), .sw_div(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .regulator_enable_in(enable), .upstream_power_good_in(good), .forced_emulation_enable(forced),
    .slow_wake_sleep_n(wake_n), .deep_sleep_request(deep), .voltage_code(code),
    .output_voltage_sense(sense), .clock_enable_n(clock_enable_n),
    .output_power_good_o(power_good_data),
    .output_power_good_oe(output_power_good_oe), .converter_on(converter_on),
    .target_tenth_mv(target), .mode(mode), .irq(irq));
  core_host_model u_host (.pclk(pclk), .converter_on(converter_on), .target_tenth_mv(target),
    .sag(sag), .output_power_good_oe(output_power_good_oe),
    .output_power_good_o(power_good_data), .output_voltage_sense(sense),
    .output_power_good_wire(output_power_good_wire));
  task close_out;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      failures++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk
  // one apb transfer; holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {24'h00_0000, a}; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin failures++; close_out(); end
  endtask : apb
  // bounded wait for clock enable (0) or power good release (1)
  task wait_low(input int sel);
    waited = 0;
    while ((sel == 0 ? clock_enable_n : output_power_good_oe) !== 1'b0) begin
      @(posedge pclk);
      waited++;
      if (waited > 2000) begin failures++; close_out(); end
    end
  endtask : wait_low
  function logic [15:0] volts(input logic [6:0] c);
    return 16'(15000 - 125 * 32'(c));
  endfunction : volts
  task t_regs;
    apb(1'b0, core_seq_pkg::addr_ctrl, 32'h0000_0000);
    chk(rd === core_seq_pkg::ctrl_reset, "ctrl reset value");
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk(err === 1'b1 && rd === core_seq_pkg::slverr_data, "unmapped read not refused");
    apb(1'b1, core_seq_pkg::addr_target, 32'hFFFF_FFFF);
    chk(err === 1'b1, "target write not refused");
    apb(1'b1, core_seq_pkg::addr_irq_mask, 32'h0000_0000);
    apb(1'b1, core_seq_pkg::addr_ctrl, 32'h0000_0001);
  endtask : t_regs
  // boot held out of window by sag, then qualify, clock enable, power good
  task t_start;
    enable <= 1'b1; sag <= 1'b1;
    repeat (60) @(posedge pclk);
    chk(target === 16'h2EE0 && clock_enable_n === 1'b1, "boot hold");
    sag <= 1'b0;
    wait_low(0);
    chk(waited >= 20, "qualify too short");
    wait_low(1);
    chk(waited >= 45 && output_power_good_wire === 1'b1, "power good late or early");
    apb(1'b0, core_seq_pkg::addr_irq_stat, 32'h0000_0000);
    chk(rd[2:0] === 3'h3 && irq === 1'b0, "events not flagged or irq unmasked");
    apb(1'b1, core_seq_pkg::addr_irq_mask, 32'h0000_0007);
    repeat (2) @(posedge pclk);
    chk(irq === 1'b1, "mask enable ignored");
    apb(1'b1, core_seq_pkg::addr_irq_stat, 32'h0000_0003);
    repeat (2) @(posedge pclk);
    chk(irq === 1'b0, "clear ignored");
  endtask : t_start
  task t_codes;
    logic [6:0] tbl [4] = '{7'h00, 7'h01, 7'h29, 7'h40};
    foreach (tbl[i]) begin
      code <= tbl[i];
      repeat (4) @(posedge pclk);
      chk(target === volts(tbl[i]), "code decode");
    end
  endtask : t_codes
  task t_modes;
    for (int i = 0; i < 8; i++) begin
      forced <= i[0]; wake_n <= i[1]; deep <= i[2];
      repeat (4) @(posedge pclk);
      chk(mode.wide_window === (i[0] && !i[1]) && mode.fast_slew === !i[2] &&
          (mode.diode_emulation_mode === 1'b1 || !(i[0] && !i[1])), "mode");
    end
    forced <= 1'b0; wake_n <= 1'b1; deep <= 1'b0;
  endtask : t_modes
  task t_latch;
    good <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(converter_on === 1'b0 && clock_enable_n === 1'b1 && output_power_good_wire === 1'b0, "no latch");
    good <= 1'b1;
    repeat (30) @(posedge pclk);
    apb(1'b0, core_seq_pkg::addr_status, 32'h0000_0000);
    chk(converter_on === 1'b0 && rd[2:0] === 3'h5 && irq === 1'b1, "latch released");
    forced <= 1'b1; wake_n <= 1'b0; deep <= 1'b1; enable <= 1'b0;
    repeat (2) @(posedge pclk);
    enable <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(target === 16'h2EE0 && mode.diode_emulation_mode === 1'b0, "restart");
    forced <= 1'b0; wake_n <= 1'b1; deep <= 1'b0;
    wait_low(0);
    wait_low(1);
  endtask : t_latch
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_start();
    t_codes();
    t_modes();
    t_latch();
    close_out();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    failures++;
    close_out();
  end
endmodule : tb_top
